/* hdl/dcasp_pkg.sv */
// Shared constants and helpers for the DDR controller bus slave port and its bus master
package dcasp_pkg;

   // Bus widths (data_width_param, bus_address_width_param)
   localparam int DCASP_DATA_W = 32;
   localparam int DCASP_ADDR_W = 32;
   localparam int DCASP_BE_W = DCASP_DATA_W / 8;

   // Transfer type codes
   localparam logic [1:0] TRANS_IDLE = 2'h0;
   localparam logic [1:0] TRANS_BUSY = 2'h1;
   localparam logic [1:0] TRANS_NONSEQ = 2'h2;
   localparam logic [1:0] TRANS_SEQ = 2'h3;

   // Transfer size codes; a 32-bit bus stops at word
   localparam logic [2:0] SIZE_BYTE = 3'h0;
   localparam logic [2:0] SIZE_HALF = 3'h1;
   localparam logic [2:0] SIZE_WORD = 3'h2;
   localparam logic [2:0] SIZE_DWORD = 3'h3;
   localparam logic [2:0] SIZE_MAX = (DCASP_DATA_W == 64) ? SIZE_DWORD : SIZE_WORD;

   // Burst type codes
   localparam logic [2:0] BURST_SINGLE = 3'h0;
   localparam logic [2:0] BURST_INCR = 3'h1;
   localparam logic [2:0] BURST_WRAP4 = 3'h2;
   localparam logic [2:0] BURST_INCR4 = 3'h3;
   localparam logic [2:0] BURST_WRAP8 = 3'h4;
   localparam logic [2:0] BURST_INCR8 = 3'h5;
   localparam logic [2:0] BURST_WRAP16 = 3'h6;
   localparam logic [2:0] BURST_INCR16 = 3'h7;

   // Response codes; the slave never answers with the last two
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_ERROR = 2'h1;
   localparam logic [1:0] RESP_RETRY = 2'h2;
   localparam logic [1:0] RESP_SPLIT = 2'h3;

   // Command engine codes
   localparam logic [2:0] CMD_NOP = 3'h0;
   localparam logic [2:0] CMD_READ = 3'h1;
   localparam logic [2:0] CMD_WRITE = 3'h2;

   // Internal register file of the port
   localparam int REG_NUM = 4;
   localparam int REG_IDX_LSB = 2;
   localparam int REG_IDX_W = 2;
   localparam logic [DCASP_DATA_W-1:0] REG_RST = 32'h0000_0000;

   // Address map used by the master's decoder
   localparam int MAP_BASE_LSB = 28;
   localparam logic [3:0] MAP_SLV_BASE = 4'h8;
   localparam int MAP_REG_BIT = 27;

   // Byte lanes touched by a transfer of the given size and low address
   function automatic logic [DCASP_BE_W-1:0] dcasp_lane_mask(input logic [2:0] size,
                                                             input logic [1:0] lo);
      logic [DCASP_BE_W-1:0] m;
      m = 4'hF;
      case (size)
         SIZE_BYTE: m = 4'h1 << lo;
         SIZE_HALF: m = 4'h3 << {lo[1], 1'b0};
         default: m = 4'hF;
      endcase
      return m;
   endfunction

endpackage

/* hdl/dcasp_if.sv */
// Bus wires between the slave port and its bus master
`timescale 1ns/10ps
interface dcasp_if;
   import dcasp_pkg::*;

   logic HSEL;
   logic register_space_select;
   logic memory_space_select;
   logic [DCASP_ADDR_W-1:0] HADDR;
   logic [1:0] HTRANS;
   logic HWRITE;
   logic [2:0] HSIZE;
   logic [2:0] HBURST;
   logic [DCASP_DATA_W-1:0] HWDATA;
   logic HREADY;
   logic [DCASP_DATA_W-1:0] HRDATA;
   logic HREADYOUT;
   logic [1:0] HRESP;

   // Slave end
   modport slave (
      input HSEL, register_space_select, memory_space_select, HADDR, HTRANS, HWRITE,
      input HSIZE, HBURST, HWDATA, HREADY,
      output HRDATA, HREADYOUT, HRESP
   );

   // Master end, which also plays the interconnect
   modport master (
      output HSEL, register_space_select, memory_space_select, HADDR, HTRANS, HWRITE,
      output HSIZE, HBURST, HWDATA, HREADY,
      input HRDATA, HREADYOUT, HRESP
   );
endinterface

/* hdl/dcasp_master.sv */
// Bus master end: single transfers on request, with address decode and ready return
`timescale 1ns/10ps
module dcasp_master import dcasp_pkg::*; (
   input wire logic CLK_I,
   input wire logic RST_N_I,
   input wire logic REQ_I,
   input wire logic REQ_WRITE_I,
   input wire logic [DCASP_ADDR_W-1:0] REQ_ADDR_I,
   input wire logic [2:0] REQ_SIZE_I,
   input wire logic [DCASP_DATA_W-1:0] REQ_WDATA_I,
   output logic IDLE_O,
   output logic DONE_O,
   output logic [DCASP_DATA_W-1:0] RDATA_O,
   output logic ERROR_O,
   dcasp_if.master bus
);

   typedef enum logic [2:0] {
      M_IDLE = 3'h1,
      M_ADDR = 3'h2,
      M_DATA = 3'h4
   } dcasp_mstate_t;

   // Select decode of an address: slave, register space, memory space
   function automatic logic [2:0] dcasp_decode(input logic [DCASP_ADDR_W-1:0] a);
      logic hit;
      hit = (a[DCASP_ADDR_W-1:MAP_BASE_LSB] == MAP_SLV_BASE);
      return {hit, hit & a[MAP_REG_BIT], hit & ~a[MAP_REG_BIT]};
   endfunction

   dcasp_mstate_t state_r, state_nxt;
   logic [DCASP_ADDR_W-1:0] haddr_r, haddr_nxt;
   logic [1:0] htrans_r, htrans_nxt;
   logic hwrite_r, hwrite_nxt;
   logic [2:0] hsize_r, hsize_nxt;
   logic [2:0] sel_r, sel_nxt;
   logic [DCASP_DATA_W-1:0] hwdata_r, hwdata_nxt;
   logic [DCASP_DATA_W-1:0] hold_r, hold_nxt;
   logic idle_r, idle_nxt;
   logic done_r, done_nxt;
   logic [DCASP_DATA_W-1:0] rdata_r, rdata_nxt;
   logic err_r, err_nxt;

   // Selects are a pure decode of the launched address, so they track it exactly
   assign bus.HADDR = haddr_r;
   assign bus.HTRANS = htrans_r;
   assign bus.HWRITE = hwrite_r;
   assign bus.HSIZE = hsize_r;
   assign bus.HBURST = BURST_SINGLE;
   assign bus.HWDATA = hwdata_r;
   assign bus.HSEL = sel_r[2];
   assign bus.register_space_select = sel_r[1];
   assign bus.memory_space_select = sel_r[0];
   // Only one slave, so its ready is the bus ready
   assign bus.HREADY = bus.HREADYOUT;
   assign IDLE_O = idle_r;
   assign DONE_O = done_r;
   assign RDATA_O = rdata_r;
   assign ERROR_O = err_r;

   // Next values of the transfer sequencer
   always_comb begin
      state_nxt = state_r;
      haddr_nxt = haddr_r;
      htrans_nxt = htrans_r;
      hwrite_nxt = hwrite_r;
      hsize_nxt = hsize_r;
      sel_nxt = sel_r;
      hwdata_nxt = hwdata_r;
      hold_nxt = hold_r;
      idle_nxt = idle_r;
      done_nxt = 1'b0;
      rdata_nxt = rdata_r;
      err_nxt = err_r;
      unique case (state_r)
         M_IDLE: begin
            if (REQ_I) begin
               htrans_nxt = TRANS_NONSEQ;
               haddr_nxt = REQ_ADDR_I;
               hwrite_nxt = REQ_WRITE_I;
               hsize_nxt = REQ_SIZE_I;
               sel_nxt = dcasp_decode(REQ_ADDR_I);
               hold_nxt = REQ_WDATA_I;
               idle_nxt = 1'b0;
               state_nxt = M_ADDR;
            end
         end
         M_ADDR: begin
            if (bus.HREADY) begin
               htrans_nxt = TRANS_IDLE;
               hwdata_nxt = hold_r;
               state_nxt = M_DATA;
            end
         end
         M_DATA: begin
            // Wait states stretch the data phase; write data stays put
            if (bus.HREADY) begin
               done_nxt = 1'b1;
               rdata_nxt = bus.HRDATA;
               err_nxt = (bus.HRESP == RESP_ERROR);
               idle_nxt = 1'b1;
               state_nxt = M_IDLE;
            end
         end
      endcase
   end

   // Registers of the transfer sequencer
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         state_r <= M_IDLE;
         haddr_r <= '0;
         htrans_r <= TRANS_IDLE;
         hwrite_r <= 1'b0;
         hsize_r <= SIZE_BYTE;
         sel_r <= 3'h0;
         hwdata_r <= '0;
         hold_r <= '0;
         idle_r <= 1'b1;
         done_r <= 1'b0;
         rdata_r <= '0;
         err_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         haddr_r <= haddr_nxt;
         htrans_r <= htrans_nxt;
         hwrite_r <= hwrite_nxt;
         hsize_r <= hsize_nxt;
         sel_r <= sel_nxt;
         hwdata_r <= hwdata_nxt;
         hold_r <= hold_nxt;
         idle_r <= idle_nxt;
         done_r <= done_nxt;
         rdata_r <= rdata_nxt;
         err_r <= err_nxt;
      end
   end

endmodule

/* hdl/dcasp_slave.sv */
// Bus slave port of the DDR controller: register space and memory command bridge
`timescale 1ns/10ps
module dcasp_slave import dcasp_pkg::*; (
   input wire logic CLK_I,
   input wire logic RST_N_I,
   input wire logic DOUBLE_RATE_CLOCK_I,
   dcasp_if.slave bus,
   output logic [2:0] ENG_CMD_O,
   output logic [DCASP_ADDR_W-1:0] ENG_ADDR_O,
   output logic [DCASP_BE_W-1:0] ENG_BE_O,
   output logic [DCASP_DATA_W-1:0] ENG_DATAIN_O,
   output logic ENG_DATAIN_STROBE_O,
   input wire logic ENG_BUSY_I,
   input wire logic ENG_DATAIN_VALID_I,
   input wire logic [DCASP_DATA_W-1:0] ENG_DATAOUT_I,
   input wire logic ENG_DATAOUT_VALID_I,
   output logic DOUBLE_RATE_PHASE_O
);

   typedef enum logic [3:0] {
      ST_READY = 4'h1,
      ST_CMD = 4'h2,
      ST_WAIT = 4'h4,
      ST_ERR = 4'h8
   } dcasp_state_t;

   typedef logic [DCASP_DATA_W-1:0] dcasp_word_t;

   dcasp_state_t state_r, state_nxt;
   logic hready_r, hready_nxt;
   logic [1:0] resp_r, resp_nxt;
   dcasp_word_t rdata_r, rdata_nxt;
   logic wr_pend_r, wr_pend_nxt;
   logic [REG_IDX_W-1:0] wr_idx_r, wr_idx_nxt;
   logic [DCASP_BE_W-1:0] wr_be_r, wr_be_nxt;
   logic mem_wr_r, mem_wr_nxt;
   logic [2:0] cmd_r, cmd_nxt;
   logic [DCASP_ADDR_W-1:0] eaddr_r, eaddr_nxt;
   logic [DCASP_BE_W-1:0] ebe_r, ebe_nxt;
   dcasp_word_t edata_r, edata_nxt;
   logic estb_r, estb_nxt;
   logic dbl_r;
   dcasp_word_t regs_r [REG_NUM];
   dcasp_word_t regs_nxt [REG_NUM];

   logic active;
   logic accept;
   logic to_reg;
   logic to_mem;
   logic bad;
   logic [REG_IDX_W-1:0] idx;
   logic [DCASP_BE_W-1:0] lanes;

   // Bus outputs, all registered
   assign bus.HREADYOUT = hready_r;
   assign bus.HRESP = resp_r;
   assign bus.HRDATA = rdata_r;
   assign ENG_CMD_O = cmd_r;
   assign ENG_ADDR_O = eaddr_r;
   assign ENG_BE_O = ebe_r;
   assign ENG_DATAIN_O = edata_r;
   assign ENG_DATAIN_STROBE_O = estb_r;
   assign DOUBLE_RATE_PHASE_O = dbl_r;

   // Address phase decode; IDLE and BUSY are not transfers and get no action
   assign active = bus.HTRANS[1];
   // NONSEQ and SEQ beats of any burst are each taken on their own address
   assign accept = (state_r == ST_READY) & bus.HREADY & bus.HSEL & active;
   // Register select wins should the decoder assert both
   assign to_reg = bus.HSEL & bus.register_space_select;
   assign to_mem = bus.HSEL & bus.memory_space_select & ~to_reg;
   // Sizes wider than the bus, or a select into neither space, are refused
   assign bad = (bus.HSIZE > SIZE_MAX) | ~(to_reg | to_mem);
   assign idx = bus.HADDR[REG_IDX_LSB +: REG_IDX_W];
   assign lanes = dcasp_lane_mask(bus.HSIZE, bus.HADDR[1:0]);

   // Next values of the bus sequencer and engine command
   always_comb begin
      state_nxt = state_r;
      hready_nxt = hready_r;
      resp_nxt = resp_r;
      rdata_nxt = rdata_r;
      wr_pend_nxt = wr_pend_r;
      wr_idx_nxt = wr_idx_r;
      wr_be_nxt = wr_be_r;
      mem_wr_nxt = mem_wr_r;
      cmd_nxt = cmd_r;
      eaddr_nxt = eaddr_r;
      ebe_nxt = ebe_r;
      edata_nxt = edata_r;
      estb_nxt = 1'b0;
      unique case (state_r)
         ST_READY: begin
            // Any data phase finishing in the next cycle ends with OKAY
            hready_nxt = 1'b1;
            resp_nxt = RESP_OKAY;
            wr_pend_nxt = 1'b0;
            if (accept) begin
               if (bad) begin
                  hready_nxt = 1'b0;
                  resp_nxt = RESP_ERROR;
                  state_nxt = ST_ERR;
               end else if (to_reg) begin
                  if (bus.HWRITE) begin
                     // Write data only arrives in the next cycle
                     wr_pend_nxt = 1'b1;
                     wr_idx_nxt = idx;
                     wr_be_nxt = lanes;
                  end else begin
                     // Forwarded view covers a write finishing this cycle
                     rdata_nxt = regs_nxt[idx];
                  end
               end else begin
                  cmd_nxt = bus.HWRITE ? CMD_WRITE : CMD_READ;
                  eaddr_nxt = bus.HADDR;
                  ebe_nxt = lanes;
                  mem_wr_nxt = bus.HWRITE;
                  hready_nxt = 1'b0;
                  state_nxt = ST_CMD;
               end
            end
         end
         ST_CMD: begin
            // Command stands until the engine is free to take it
            if (!ENG_BUSY_I) begin
               cmd_nxt = CMD_NOP;
               state_nxt = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (mem_wr_r && ENG_DATAIN_VALID_I) begin
               edata_nxt = bus.HWDATA;
               estb_nxt = 1'b1;
               hready_nxt = 1'b1;
               state_nxt = ST_READY;
            end else if (!mem_wr_r && ENG_DATAOUT_VALID_I) begin
               rdata_nxt = ENG_DATAOUT_I;
               hready_nxt = 1'b1;
               state_nxt = ST_READY;
            end
         end
         ST_ERR: begin
            // Second error cycle: ready high, response still ERROR
            hready_nxt = 1'b1;
            state_nxt = ST_READY;
         end
      endcase
   end

   // Registers of the bus sequencer and engine command
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         state_r <= ST_READY;
         hready_r <= 1'b1;
         resp_r <= RESP_OKAY;
         rdata_r <= '0;
         wr_pend_r <= 1'b0;
         wr_idx_r <= '0;
         wr_be_r <= '0;
         mem_wr_r <= 1'b0;
         cmd_r <= CMD_NOP;
         eaddr_r <= '0;
         ebe_r <= '0;
         edata_r <= '0;
         estb_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         hready_r <= hready_nxt;
         resp_r <= resp_nxt;
         rdata_r <= rdata_nxt;
         wr_pend_r <= wr_pend_nxt;
         wr_idx_r <= wr_idx_nxt;
         wr_be_r <= wr_be_nxt;
         mem_wr_r <= mem_wr_nxt;
         cmd_r <= cmd_nxt;
         eaddr_r <= eaddr_nxt;
         ebe_r <= ebe_nxt;
         edata_r <= edata_nxt;
         estb_r <= estb_nxt;
      end
   end

   // Register file: byte lanes of a pending write merge in during its data phase
   always_comb begin
      for (int r = 0; r < REG_NUM; r++) begin
         regs_nxt[r] = regs_r[r];
      end
      if (wr_pend_r && state_r == ST_READY) begin
         for (int b = 0; b < DCASP_BE_W; b++) begin
            if (wr_be_r[b]) begin
               regs_nxt[wr_idx_r][b*8 +: 8] = bus.HWDATA[b*8 +: 8];
            end
         end
      end
   end

   // Register file storage
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         for (int r = 0; r < REG_NUM; r++) begin
            regs_r[r] <= REG_RST;
         end
      end else begin
         for (int r = 0; r < REG_NUM; r++) begin
            regs_r[r] <= regs_nxt[r];
         end
      end
   end

   // Double rate clock is only sampled here; its phase goes on to the data path
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         dbl_r <= 1'b0;
      end else begin
         dbl_r <= DOUBLE_RATE_CLOCK_I;
      end
   end

endmodule

/* tb/dcasp_asserts.sv */
// Bus protocol checker for the slave port, watching the interface wires
`timescale 1ns/10ps
module dcasp_asserts import dcasp_pkg::*; (
   input wire logic CLK_I,
   input wire logic RST_N_I,
   input wire logic HSEL,
   input wire logic register_space_select,
   input wire logic memory_space_select,
   input wire logic [1:0] HTRANS,
   input wire logic [2:0] HSIZE,
   input wire logic HREADY,
   input wire logic HREADYOUT,
   input wire logic [1:0] HRESP
);
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);

   // Address phase accepted by the slave, and the two-step error answer
   sequence taken_s;
      HREADY && HREADYOUT && HSEL && HTRANS[1];
   endsequence
   sequence err_s;
      !HREADYOUT && HRESP == RESP_ERROR ##1 HREADYOUT && HRESP == RESP_ERROR;
   endsequence

   // Response and ready relations
   a_resp_legal: assert property (HRESP != RESP_RETRY && HRESP != RESP_SPLIT)
      else $error("retry or split response seen");
   a_size_refused: assert property (taken_s ##0 HSIZE > SIZE_MAX |=> err_s)
      else $error("oversized transfer not refused");
   a_error_shape: assert property (HRESP == RESP_ERROR && !HREADYOUT |=>
      HRESP == RESP_ERROR && HREADYOUT)
      else $error("error answer not two cycles");
   a_error_starts: assert property ($rose(HRESP == RESP_ERROR) |-> !HREADYOUT)
      else $error("error began with ready high");
   a_reg_zero_wait: assert property (taken_s ##0 register_space_select &&
      HSIZE <= SIZE_MAX |=> HREADYOUT && HRESP == RESP_OKAY)
      else $error("register access was stretched");
   a_mem_stretch: assert property (taken_s ##0 !register_space_select &&
      memory_space_select && HSIZE <= SIZE_MAX |=> !HREADYOUT [*2])
      else $error("memory access not held off");
   a_idle_okay: assert property (HREADY && !HTRANS[1] |=>
      HREADYOUT && HRESP == RESP_OKAY)
      else $error("idle or busy not answered at once");
   a_unsel_okay: assert property (HREADY && !HSEL |=>
      HREADYOUT && HRESP == RESP_OKAY)
      else $error("unselected transfer answered");
   a_wait_bounded: assert property (!HREADYOUT |-> ##[1:60] HREADYOUT)
      else $error("wait state never ended");
endmodule

/* tb/testbench.sv */
// Self-checking bench joining the bus master and the slave port
`timescale 1ns/10ps
module testbench import dcasp_pkg::*; ;
   localparam logic [31:0] REG_A = 32'h8800_0000;
   localparam logic [31:0] MEM_A = 32'h8000_0000;
   logic clk = 1'h0;
   logic rst_n = 1'h0;
   logic dbl_clk = 1'h0;
   logic req = 1'h0;
   logic req_wr = 1'h0;
   logic [31:0] req_addr = 32'h0;
   logic [2:0] req_size = 3'h0;
   logic [31:0] req_wdata = 32'h0;
   logic eng_busy = 1'h0;
   logic din_vld = 1'h0;
   logic dout_vld = 1'h0;
   logic [31:0] dout = 32'h0;
   logic idle, done, err, eng_strobe, phase;
   logic [31:0] rdata, eng_addr, eng_din;
   logic [2:0] eng_cmd;
   logic [3:0] eng_be, exp_be;
   logic [31:0] exp_addr, exp_din;
   int stall = 0;
   int errors = 0;
   int comparisons = 0;

   // Bus clock and a double-rate clock offset so it never toggles on a bus edge
   always #50 clk = ~clk;
   initial begin
      #12;
      forever #25 dbl_clk = ~dbl_clk;
   end

   dcasp_if bus_if ();
   dcasp_master u_dcasp_master (.CLK_I(clk), .RST_N_I(rst_n), .REQ_I(req),
      .REQ_WRITE_I(req_wr), .REQ_ADDR_I(req_addr), .REQ_SIZE_I(req_size),
      .REQ_WDATA_I(req_wdata), .IDLE_O(idle), .DONE_O(done), .RDATA_O(rdata),
      .ERROR_O(err), .bus(bus_if.master));
   dcasp_slave u_dcasp_slave (.CLK_I(clk), .RST_N_I(rst_n), .DOUBLE_RATE_CLOCK_I(dbl_clk),
      .bus(bus_if.slave), .ENG_CMD_O(eng_cmd), .ENG_ADDR_O(eng_addr), .ENG_BE_O(eng_be),
      .ENG_DATAIN_O(eng_din), .ENG_DATAIN_STROBE_O(eng_strobe), .ENG_BUSY_I(eng_busy),
      .ENG_DATAIN_VALID_I(din_vld), .ENG_DATAOUT_I(dout), .ENG_DATAOUT_VALID_I(dout_vld),
      .DOUBLE_RATE_PHASE_O(phase));
   dcasp_asserts u_dcasp_asserts (.CLK_I(clk), .RST_N_I(rst_n), .HSEL(bus_if.HSEL),
      .register_space_select(bus_if.register_space_select),
      .memory_space_select(bus_if.memory_space_select), .HTRANS(bus_if.HTRANS),
      .HSIZE(bus_if.HSIZE), .HREADY(bus_if.HREADY), .HREADYOUT(bus_if.HREADYOUT),
      .HRESP(bus_if.HRESP));

   // Counted compare with a one-line report on mismatch
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Verdict and end of run
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // One single transfer through the master's request side
   task automatic xfer(input logic wr, input logic [31:0] a, input logic [2:0] sz,
                       input logic [31:0] wd, input logic [31:0] exp_rd, input logic exp_err);
      int n;
      n = 0;
      while (idle !== 1'h1 && n < 100) begin
         @(posedge clk); #1;
         n++;
      end
      req = 1'h1;
      req_wr = wr;
      req_addr = a;
      req_size = sz;
      req_wdata = wd;
      @(posedge clk); #1;
      req = 1'h0;
      n = 0;
      // Bounded so a missing completion shows as a mismatch, not a hang
      while (done !== 1'h1 && n < 100) begin
         @(posedge clk); #1;
         n++;
      end
      check("done", 1'h1, done);
      check("error", exp_err, err);
      if (!wr && !exp_err) check("rdata", exp_rd, rdata);
   endtask

   // Memory transfer: sets what the engine stand-in expects to see
   task automatic memx(input logic wr, input logic [31:0] a, input logic [2:0] sz,
                       input int st, input logic [31:0] d);
      exp_addr = a;
      exp_din = d;
      stall = st;
      case (sz)
         SIZE_BYTE: exp_be = 4'h1 << a[1:0];
         SIZE_HALF: exp_be = 4'h3 << {a[1], 1'h0};
         default: exp_be = 4'hF;
      endcase
      xfer(wr, MEM_A | a, sz, d, d, 1'h0);
   endtask

   // Engine stand-in: optional busy stall, then one data beat two cycles later
   initial begin
      logic rd;
      forever begin
         @(posedge clk); #1;
         if (eng_cmd === CMD_READ || eng_cmd === CMD_WRITE) begin
            rd = (eng_cmd === CMD_READ);
            check("eng_cmd", req_wr ? CMD_WRITE : CMD_READ, eng_cmd);
            check("eng_addr", MEM_A | exp_addr, eng_addr);
            check("eng_be", exp_be, eng_be);
            if (stall > 0) begin
               eng_busy = 1'h1;
               repeat (stall) @(posedge clk);
               #1;
               eng_busy = 1'h0;
               check("eng_hold", rd ? CMD_READ : CMD_WRITE, eng_cmd);
            end
            @(posedge clk); #1;
            check("eng_nop", CMD_NOP, eng_cmd);
            @(posedge clk); #1;
            dout = exp_din;
            dout_vld = rd;
            din_vld = !rd;
            @(posedge clk); #1;
            dout_vld = 1'h0;
            din_vld = 1'h0;
            dout = ~exp_din;
            check("eng_strobe", !rd, eng_strobe);
            if (!rd) check("eng_din", exp_din, eng_din);
         end
      end
   end

   // Watchdog, far beyond the hundred or so cycles the tests take
   initial begin
      #200000;
      errors++;
      $display("watchdog expired");
      complete_run;
   end

   // Test sequence
   initial begin
      repeat (6) @(posedge clk);
      #1;
      rst_n = 1'h1;
      check("idle", 1'h1, idle);
      check("phase_rst", 1'h0, phase);
      xfer(1'h0, REG_A + 8, SIZE_WORD, 32'h0, 32'h0, 1'h0);
      check("phase", 1'h1, phase);
      for (int i = 0; i < 4; i++) xfer(1'h1, REG_A + 4 * i, SIZE_WORD, 32'hA500_0000 + i,
                                       32'h0, 1'h0);
      for (int i = 0; i < 4; i++) xfer(1'h0, REG_A + 4 * i, SIZE_WORD, 32'h0,
                                       32'hA500_0000 + i, 1'h0);
      xfer(1'h1, REG_A + 6, SIZE_BYTE, 32'hCCCC_CCCC, 32'h0, 1'h0);
      xfer(1'h1, REG_A + 10, SIZE_HALF, 32'hDDDD_DDDD, 32'h0, 1'h0);
      xfer(1'h0, REG_A + 4, SIZE_WORD, 32'h0, 32'hA5CC_0001, 1'h0);
      xfer(1'h0, REG_A + 8, SIZE_WORD, 32'h0, 32'hDDDD_0002, 1'h0);
      $display("test registers finished");
      memx(1'h0, 32'h0000_1230, SIZE_WORD, 0, 32'h1234_5678);
      memx(1'h0, 32'h0000_2000, SIZE_WORD, 3, 32'h8765_4321);
      memx(1'h1, 32'h0000_3003, SIZE_BYTE, 2, 32'h5A5A_5A5A);
      memx(1'h1, 32'h0000_3002, SIZE_HALF, 0, 32'hC3C3_C3C3);
      memx(1'h1, 32'h0000_4004, SIZE_WORD, 1, 32'h0F0F_0F0F);
      $display("test memory finished");
      xfer(1'h1, REG_A, SIZE_DWORD, 32'hFFFF_FFFF, 32'h0, 1'h1);
      xfer(1'h0, REG_A, SIZE_WORD, 32'h0, 32'hA500_0000, 1'h0);
      xfer(1'h0, MEM_A, SIZE_DWORD, 32'h0, 32'h0, 1'h1);
      xfer(1'h1, 32'h1000_0000, SIZE_WORD, 32'h1111_1111, 32'h0, 1'h0);
      $display("test refusals finished");
      @(posedge clk); #1;
      rst_n = 1'h0;
      @(posedge clk); #1;
      check("idle_rst", 1'h1, idle);
      rst_n = 1'h1;
      xfer(1'h0, REG_A + 4, SIZE_WORD, 32'h0, 32'h0, 1'h0);
      $display("test reset finished");
      complete_run;
   end
endmodule
